// ---- src/load_word_zero_pkg.sv ----
package load_word_zero_pkg;

   // Instruction field positions, big-endian bit numbering mapped to [31:0]
   localparam int OPCD_HI = 31;
   localparam int OPCD_LO = 26;
   localparam int TGT_HI = 25;
   localparam int TGT_LO = 21;
   localparam int BASE_HI = 20;
   localparam int BASE_LO = 16;
   localparam int IDX_HI = 15;
   localparam int IDX_LO = 11;
   localparam int DISP_HI = 15;
   localparam int DISP_LO = 0;
   localparam int XO_HI = 10;
   localparam int XO_LO = 1;

   localparam logic [5:0] OP_LOAD_UPD_IMM = 6'h21;
   localparam logic [5:0] OP_EXTENDED = 6'h1f;
   localparam logic [9:0] XO_LOAD_UPD_IDX = 10'h037;
   localparam logic [9:0] XO_LOAD_IDX = 10'h017;
   localparam logic [4:0] REG_ZERO = 5'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MEM = 2'b01,
      ST_WB = 2'b11
   } state_type;

   typedef enum logic [1:0] {
      FORM_NONE = 2'h0,
      FORM_UPD_IMM = 2'h1,
      FORM_UPD_IDX = 2'h2,
      FORM_IDX = 2'h3
   } form_type;

   typedef struct packed {
      logic we;
      logic [4:0] addr;
      logic [31:0] data;
   } reg_write_type;

   typedef struct packed {
      state_type state;
      form_type form;
      logic [4:0] tgt;
      logic [4:0] base;
      logic [31:0] eff_addr;
      logic mem_req;
      logic [31:0] load_data;
      reg_write_type tgt_wr;
      reg_write_type base_wr;
      logic done;
      logic fault;
      logic illegal;
      logic flt_held;
   } core_state_type;

endpackage : load_word_zero_pkg

// ---- src/load_word_zero_exec.sv ----
`timescale 1ns/100ps
`default_nettype none

module load_word_zero_exec (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   output logic issue_ready,
   output logic [4:0] rd_base_sel,
   output logic [4:0] rd_index_sel,
   input wire logic [31:0] rd_base_data,
   input wire logic [31:0] rd_index_data,
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_align_fault,
   input wire logic mem_storage_fault,
   output load_word_zero_pkg::reg_write_type tgt_wr,
   output load_word_zero_pkg::reg_write_type base_wr,
   output logic done,
   output logic fault,
   output logic illegal
);

   load_word_zero_pkg::core_state_type cur_ff;
   load_word_zero_pkg::core_state_type nxt_cur;
   logic [5:0] opcd;
   logic [9:0] xo;
   logic [31:0] disp_ext;
   load_word_zero_pkg::form_type dec_form;
   logic [4:0] tgt_field;
   logic [31:0] ea_base_term;
   logic [31:0] ea_offset_term;
   logic [31:0] ea_sum;
   logic tgt_we_ok;
   logic base_upd_ok;
   logic dec_known;
   logic issue_take;

   ////////////////////////////////////////////////////////////////////////////
   // Decode, read-port selection follows the instruction on issue

   assign opcd = issue_instr[load_word_zero_pkg::OPCD_HI:load_word_zero_pkg::OPCD_LO];
   assign xo = issue_instr[load_word_zero_pkg::XO_HI:load_word_zero_pkg::XO_LO];
   assign tgt_field = issue_instr[load_word_zero_pkg::TGT_HI:load_word_zero_pkg::TGT_LO];
   // Read selects follow the raw fields; the register file answers in the same cycle
   assign rd_base_sel = issue_instr[load_word_zero_pkg::BASE_HI:load_word_zero_pkg::BASE_LO];
   assign rd_index_sel = issue_instr[load_word_zero_pkg::IDX_HI:load_word_zero_pkg::IDX_LO];
   assign issue_take = issue_valid && issue_ready;

   // Offset bits copy straight through; every bit above them repeats the sign
   generate
      for (genvar i = 0; i < $bits(disp_ext); i++) begin : g_disp_ext
         if (i > load_word_zero_pkg::DISP_HI - load_word_zero_pkg::DISP_LO) begin : g_sign
            assign disp_ext[i] = issue_instr[load_word_zero_pkg::DISP_HI];
         end else begin : g_field
            assign disp_ext[i] = issue_instr[load_word_zero_pkg::DISP_LO + i];
         end
      end
   endgenerate

   always_comb begin
      dec_form = load_word_zero_pkg::FORM_NONE;
      if (opcd == load_word_zero_pkg::OP_LOAD_UPD_IMM) begin
         dec_form = load_word_zero_pkg::FORM_UPD_IMM;
      end else if (opcd == load_word_zero_pkg::OP_EXTENDED) begin
         if (xo == load_word_zero_pkg::XO_LOAD_UPD_IDX) begin
            dec_form = load_word_zero_pkg::FORM_UPD_IDX;
         end else if (xo == load_word_zero_pkg::XO_LOAD_IDX) begin
            dec_form = load_word_zero_pkg::FORM_IDX;
         end
      end
   end

   // Anything else is reported as illegal, never executed
   assign dec_known = (dec_form != load_word_zero_pkg::FORM_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Effective address: one adder serves all three forms

   always_comb begin
      // A zero base field stands for the value zero, not for register zero
      if (rd_base_sel == load_word_zero_pkg::REG_ZERO) begin
         ea_base_term = '0;
      end else begin
         ea_base_term = rd_base_data;
      end
      if (dec_form == load_word_zero_pkg::FORM_UPD_IMM) begin
         ea_offset_term = disp_ext;
      end else begin
         ea_offset_term = rd_index_data;
      end
      ea_sum = ea_base_term + ea_offset_term;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write qualification, judged from what the access left behind

   always_comb begin
      // A faulting access leaves every register as it was
      tgt_we_ok = !cur_ff.flt_held;
      base_upd_ok = !cur_ff.flt_held;
      if (cur_ff.form == load_word_zero_pkg::FORM_IDX) begin
         base_upd_ok = 1'b0;
      end
      if (cur_ff.base == load_word_zero_pkg::REG_ZERO) begin
         base_upd_ok = 1'b0;
      end
      // Base equal to target: the loaded word must not be overwritten
      if (cur_ff.base == cur_ff.tgt) begin
         base_upd_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   // Three steps: take and add, wait for the answer, write back

   always_comb begin
      nxt_cur = cur_ff;
      // Pulses fall back to zero unless a state raises them
      nxt_cur.tgt_wr.we = 1'b0;
      nxt_cur.base_wr.we = 1'b0;
      nxt_cur.done = 1'b0;
      nxt_cur.fault = 1'b0;
      nxt_cur.illegal = 1'b0;
      case (cur_ff.state)
         load_word_zero_pkg::ST_IDLE: begin
            if (issue_take) begin
               nxt_cur.form = dec_form;
               nxt_cur.tgt = tgt_field;
               nxt_cur.base = rd_base_sel;
               if (!dec_known) begin
                  // Not one of ours: flag it and stay idle
                  nxt_cur.illegal = 1'b1;
                  nxt_cur.done = 1'b1;
               end else begin
                  // Operands are caught here; the register file may change after issue
                  nxt_cur.eff_addr = ea_sum;
                  // Request is registered, so its address is already stable
                  nxt_cur.mem_req = 1'b1;
                  nxt_cur.state = load_word_zero_pkg::ST_MEM;
               end
            end
         end
         load_word_zero_pkg::ST_MEM: begin
            if (mem_ack) begin
               nxt_cur.mem_req = 1'b0;
               nxt_cur.load_data = mem_rdata;
               // Held privately until write-back so that fault pulses with done
               nxt_cur.flt_held = mem_align_fault | mem_storage_fault;
               nxt_cur.state = load_word_zero_pkg::ST_WB;
            end
         end
         load_word_zero_pkg::ST_WB: begin
            // Both writes and the fault report leave together with done
            nxt_cur.tgt_wr.we = tgt_we_ok;
            nxt_cur.tgt_wr.addr = cur_ff.tgt;
            nxt_cur.tgt_wr.data = cur_ff.load_data;
            nxt_cur.base_wr.we = base_upd_ok;
            nxt_cur.base_wr.addr = cur_ff.base;
            nxt_cur.base_wr.data = cur_ff.eff_addr;
            nxt_cur.fault = cur_ff.flt_held;
            nxt_cur.flt_held = 1'b0;
            nxt_cur.done = 1'b1;
            nxt_cur.state = load_word_zero_pkg::ST_IDLE;
         end
         default: begin
            nxt_cur.state = load_word_zero_pkg::ST_IDLE;
            nxt_cur.mem_req = 1'b0;
            nxt_cur.flt_held = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Clock enable low freezes every bit, registered outputs included
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else if (clk_en) begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; no exception-register or condition-field port exists at all

   // Ready and the two read selects are the combinational outputs; ready drops with the clock enable
   assign issue_ready = (cur_ff.state == load_word_zero_pkg::ST_IDLE) && clk_en;

   // The request and its address come straight from the state register
   assign mem_req = cur_ff.mem_req;
   assign mem_addr = cur_ff.eff_addr;

   // Write ports carry one-cycle enables; address and data linger harmlessly
   assign tgt_wr = cur_ff.tgt_wr;
   assign base_wr = cur_ff.base_wr;

   // Done and fault pulse in the write-back cycle; illegal pulses with done the cycle after issue
   assign done = cur_ff.done;
   assign fault = cur_ff.fault;
   assign illegal = cur_ff.illegal;

endmodule : load_word_zero_exec

`default_nettype wire

// ---- sim/mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input wire logic clock,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [2:0] mode,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   output logic [1:0] mem_flt
);
   logic wait_ff;
   // Mode bit 2 adds a wait state, bits 1:0 pick the faults
   always_ff @(posedge clock) wait_ff <= mem_req && !mem_ack;
   assign mem_ack = mem_req && (!mode[2] || wait_ff);
   // Junk off the answer, so a late sample never looks like the word
   assign mem_rdata = mem_ack ? ~mem_addr : mem_addr;
   assign mem_flt = mem_ack ? mode[1:0] : 2'h0;
endmodule : mem_model
`default_nettype wire

// ---- sim/load_word_zero_exec_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module load_word_zero_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic issue_ready,
   input wire logic mem_req,
   input wire logic mem_ack,
   input wire load_word_zero_pkg::reg_write_type tgt_wr,
   input wire load_word_zero_pkg::reg_write_type base_wr,
   input wire logic done,
   input wire logic fault,
   input wire logic illegal
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_busy_refuse: assert property (mem_req |-> !issue_ready)
      else $error("busy");
   a_ack_finish: assert property (mem_req && mem_ack |-> ##2 done)
      else $error("late");
   a_fault_mute: assert property (fault |-> done && !tgt_wr.we && !base_wr.we)
      else $error("wrote");
   a_base_legal: assert property (base_wr.we |-> tgt_wr.we &&
      base_wr.addr != 5'h00 && base_wr.addr != tgt_wr.addr) else $error("base");
   a_write_done: assert property (tgt_wr.we |-> done && !illegal)
      else $error("wdone");
   a_we_pulse: assert property (tgt_wr.we |=> !tgt_wr.we && (!done || illegal))
      else $error("pulse");
   a_illegal_mute: assert property (illegal |-> done && !mem_req && !tgt_wr.we)
      else $error("illegal");
   a_done_ready: assert property (done |-> issue_ready)
      else $error("ready");
endmodule : load_word_zero_checker
bind load_word_zero_exec load_word_zero_checker chk_u (.clock, .rst_n, .issue_ready, .mem_req,
   .mem_ack, .tgt_wr, .base_wr, .done, .fault, .illegal);
`default_nettype wire

// ---- sim/load_word_zero_exec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module load_word_zero_exec_tb;
   logic clock = 1'b0, rst_n, clk_en, issue_valid, issue_ready, mem_req, mem_ack, done, fault;
   logic illegal;
   logic [31:0] instr, mem_addr, mem_rdata;
   logic [4:0] bsel, xsel;
   logic [2:0] mode;
   logic [1:0] flt;
   load_word_zero_pkg::reg_write_type tgt_wr, base_wr;
   int err_count = 0, tests_run = 0;
   load_word_zero_exec dut_u (.clock, .rst_n, .clk_en, .issue_valid, .issue_instr(instr),
      .issue_ready, .rd_base_sel(bsel), .rd_index_sel(xsel), .rd_base_data({bsel, 27'h10}),
      .rd_index_data({xsel, 27'h10}), .mem_req, .mem_addr, .mem_ack, .mem_rdata,
      .mem_align_fault(flt[0]), .mem_storage_fault(flt[1]), .tgt_wr, .base_wr, .done, .fault,
      .illegal);
   mem_model mem_u (.clock, .mem_req, .mem_addr, .mode, .mem_ack, .mem_rdata, .mem_flt(flt));
   initial forever #25 clock = ~clock;
   task automatic chk(input string n, input logic [37:0] e, s);
      tests_run++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   // Form k: 0 immediate update, 1 indexed update, 2 plain indexed
   task automatic run(input logic [1:0] k, input logic [4:0] t, b, input logic [15:0] d,
         input logic [2:0] m);
      logic [31:0] ea;
      ea = (b != 5'h00 ? {b, 27'h10} : 32'h0) + (k != 2'h0 ? {d[15:11], 27'h10} : {{16{d[15]}}, d});
      instr = {k != 2'h0 ? 6'h1f : 6'h21, t, b,
         k == 2'h0 ? d : {d[15:11], k == 2'h1 ? 10'h037 : 10'h017, 1'b0}};
      {issue_valid, mode} = {1'b1, m};
      @(negedge clock);
      issue_valid = 1'b0;
      chk("mem_addr", ea, mem_addr);
      for (int i = 0; i < 9 && done !== 1'b1; i++) @(negedge clock);
      chk("done_fault", {1'b1, m[1:0] != 2'h0}, {done, fault});
      if (done !== 1'b1) return;
      chk("tgt_wr", m[1:0] != 2'h0 ? {1'b0, tgt_wr[36:0]} : {1'b1, t, ~ea}, tgt_wr);
      chk("base_wr", k != 2'h2 && b != 5'h00 && b != t && m[1:0] == 2'h0 ? {1'b1, b, ea} :
         {1'b0, base_wr[36:0]}, base_wr);
      @(negedge clock);
      $display("form %0d finished", k);
   endtask : run
   task automatic s_imm;
      run(2'h0, 5'h06, 5'h04, 16'hfffc, 3'h0);
      run(2'h0, 5'h06, 5'h00, 16'h8000, 3'h4);
   endtask : s_imm
   task automatic s_idx;
      run(2'h1, 5'h06, 5'h05, 16'h2000, 3'h4);
      run(2'h1, 5'h07, 5'h07, 16'h2000, 3'h0);
      run(2'h2, 5'h06, 5'h00, 16'h1800, 3'h4);
   endtask : s_idx
   task automatic s_odd;
      run(2'h0, 5'h03, 5'h02, 16'h0004, 3'h1);
      run(2'h1, 5'h03, 5'h02, 16'h0800, 3'h6);
      {clk_en, issue_valid, instr} = {1'b0, 1'b1, 32'h80000000};
      @(negedge clock);
      chk("ready", 0, issue_ready);
      clk_en = 1'b1;
      @(negedge clock);
      issue_valid = 1'b0;
      chk("illegal", 3, {illegal, done});
      $display("odd cases finished");
   endtask : s_odd
   initial begin
      {rst_n, clk_en, issue_valid, instr, mode} = '0;
      repeat (2) @(negedge clock);
      chk("reset_out", 38'h0, {issue_ready, mem_req, done, fault, illegal, tgt_wr.we, base_wr.we});
      {rst_n, clk_en} = 2'h3;
      s_imm();
      s_idx();
      s_odd();
      summarize();
   end
endmodule : load_word_zero_exec_tb
`default_nettype wire
